//--- voltage_detect_cfg.svh
`ifndef VOLTAGE_DETECT_CFG_SVH
`define VOLTAGE_DETECT_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define SUPPLY_MONITOR_STATUS_IDX 10'h031
`define DETECTOR_ENABLE_CONTROL_IDX 10'h032

// ----------------------------------------------------------------------------
// Reset values and field positions.
// ----------------------------------------------------------------------------
`define SUPPLY_MONITOR_STATUS_RESET 8'h08
`define DETECTOR_CTRL_WARM_RESET 8'h00
`define DETECTOR_CTRL_COLD_RESET 8'h20
`define LEVEL2_FLAG_BIT 3
`define LOW_POWER_BIT 0
`define DETECT0_BIT 5
`define DETECT2_BIT 7

// ----------------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------------
`define PCLK_PERIOD_NS 8
`define ENABLE_SETTLE_TIME_NS 20000
`define ENABLE_SETTLE_CYCLES ((`ENABLE_SETTLE_TIME_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define INIT_CYCLES 2'h3

`endif

//--- voltage_detect_pkg.sv
package voltage_detect_pkg;

  // Layout of the detector enable control register.
  typedef struct packed {
    logic detect2_en;
    logic detect1_en;
    logic detect0_en;
    logic [3:0] reserved;
    logic low_internal_power_en;
  } detector_ctrl_s;

  // Stored part of the supply monitor status register.
  typedef struct packed {
    logic [3:0] reserved_hi;
    logic [2:0] reserved_lo;
  } monitor_status_s;

  // Bus slave answer phase.
  typedef enum logic [2:0] {
    BUS_INIT = 3'b001,
    BUS_IDLE = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_e;

endpackage

//--- detect_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Holds a detection circuit off for a settling time after it is enabled.
// ----------------------------------------------------------------------------
module detect_settle_timer #(
  parameter int CYCLES = 2500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  output logic ready
);

  localparam int CW = $clog2(CYCLES + 1);

  logic en_q_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] age_reg;

  // Remembers the enable of the last cycle to find its rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q_reg <= 1'b0;
    end else begin
      en_q_reg <= enable;
    end
  end

  // Loads the wait on a rising enable and counts it down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (!enable) begin
      cnt_reg <= '0;
    end else if (!en_q_reg) begin
      cnt_reg <= CW'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Monitoring starts only once the wait has run out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready <= 1'b0;
    end else begin
      ready <= enable && en_q_reg && (cnt_reg == '0);
    end
  end

  // Counts how long the enable has been high, for checking only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_reg <= '0;
    end else if (!enable) begin
      age_reg <= '0;
    end else if (age_reg != CW'(CYCLES)) begin
      age_reg <= age_reg + 1'b1;
    end
  end

  property p_settle_wait;
    @(posedge pclk) disable iff (!presetn)
    ready |-> (age_reg == CW'(CYCLES));
  endproperty
  a_settle_wait: assert property (p_settle_wait) else $error("Detector ready before settling.");

  property p_settle_end;
    @(posedge pclk) disable iff (!presetn)
    (enable && age_reg == CW'(CYCLES)) ##1 enable |=> ready;
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("Detector not ready after settling.");

endmodule

`default_nettype wire

//--- voltage_detect_ctrl_regs.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "voltage_detect_cfg.svh"

// Summary of operation
// - Level-2 flag is read-only: 0 below threshold, 1 at/above it or circuit 2 off or settling.
// - Software, watchdog and monitor 1/2 resets leave the status register unchanged.
// - Control resets to 00h, or detect0 set on cold reset or option bit 0.
// - Software, watchdog and monitor 1/2 resets leave the control register unchanged.
// - Control writes are ignored unless the write-protect enable is set first.
// - Control bits 5, 6 and 7 enable detection circuits 0, 1 and 2.
// - A newly enabled detection circuit waits the settling delay before monitoring.
// - Level-0 reset enable acts only while detection circuit 0 is enabled.
module voltage_detect_ctrl_regs #(
  parameter int SETTLE_CYCLES = `ENABLE_SETTLE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cold_reset_cause,
  input wire logic level0_startup_option,
  input wire logic level2_cmp_above,
  input wire logic write_protect_open,
  input wire logic level0_reset_en,
  output logic [2:0] detect_power_en,
  output logic [2:0] detect_active,
  output logic low_internal_power_en,
  output logic level0_reset_active
);

  // --------------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------------
  voltage_detect_pkg::detector_ctrl_s ctrl_reg;
  voltage_detect_pkg::monitor_status_s status_reg;
  voltage_detect_pkg::bus_state_e bus_reg;
  logic [1:0] init_cnt_reg;
  logic [1:0] cold_sync_reg;
  logic [1:0] option_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic level2_flag_reg;
  logic [2:0] settled;
  logic access_done;
  logic wr_status;
  logic wr_ctrl;
  logic [7:0] read_byte;

  // Tells whether the bus address selects the register of the given index.
  function automatic logic addr_hit(input logic [11:0] addr, input logic [9:0] idx);
    addr_hit = (addr == {idx, 2'b00});
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisers.
  // --------------------------------------------------------------------------
  // Straps and the comparator come from outside the clock domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cold_sync_reg <= 2'h0;
      option_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
    end else begin
      cold_sync_reg <= {cold_sync_reg[0], cold_reset_cause};
      option_sync_reg <= {option_sync_reg[0], level0_startup_option};
      cmp_sync_reg <= {cmp_sync_reg[0], level2_cmp_above};
    end
  end

  // --------------------------------------------------------------------------
  // Start-up after reset release.
  // --------------------------------------------------------------------------
  // Waits for the synchronised straps before loading the reset value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_reg <= `INIT_CYCLES;
    end else if (init_cnt_reg != 2'h0) begin
      init_cnt_reg <= init_cnt_reg - 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Bus slave.
  // --------------------------------------------------------------------------
  assign access_done = psel && penable && pready;
  assign wr_status = access_done && pwrite && addr_hit(paddr, `SUPPLY_MONITOR_STATUS_IDX);
  assign wr_ctrl = access_done && pwrite && addr_hit(paddr, `DETECTOR_ENABLE_CONTROL_IDX);

  // Raises pready one cycle after a request is seen, once start-up is over.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_reg <= voltage_detect_pkg::BUS_INIT;
      pready <= 1'b0;
    end else begin
      case (bus_reg)
        voltage_detect_pkg::BUS_INIT: begin
          if (init_cnt_reg == 2'h0) begin
            bus_reg <= voltage_detect_pkg::BUS_IDLE;
          end
        end
        voltage_detect_pkg::BUS_IDLE: begin
          if (psel) begin
            bus_reg <= voltage_detect_pkg::BUS_DONE;
            pready <= 1'b1;
          end
        end
        voltage_detect_pkg::BUS_DONE: begin
          bus_reg <= voltage_detect_pkg::BUS_IDLE;
          pready <= 1'b0;
        end
        default: begin
          bus_reg <= voltage_detect_pkg::BUS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // Selects the read value; the flag bit is live and reserved bits are stored.
  always_comb begin
    read_byte = 8'h00;
    if (addr_hit(paddr, `SUPPLY_MONITOR_STATUS_IDX)) begin
      read_byte = {status_reg.reserved_hi, level2_flag_reg, status_reg.reserved_lo};
    end else if (addr_hit(paddr, `DETECTOR_ENABLE_CONTROL_IDX)) begin
      read_byte = ctrl_reg;
    end
  end

  // Registers read data and the error answer with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (bus_reg == voltage_detect_pkg::BUS_IDLE && psel) begin
      prdata <= {24'h0, read_byte};
      pslverr <= !addr_hit(paddr, `SUPPLY_MONITOR_STATUS_IDX) &&
                 !addr_hit(paddr, `DETECTOR_ENABLE_CONTROL_IDX);
    end else begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------
  // Only presetn clears these; other reset causes never reach them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 7'({`SUPPLY_MONITOR_STATUS_RESET} >> 1) & 7'h78 | 7'h00;
    end else if (wr_status) begin
      status_reg <= {pwdata[7:4], pwdata[2:0]};
    end
  end

  // Loads the strap-dependent reset value, then takes protected writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `DETECTOR_CTRL_WARM_RESET;
    end else if (init_cnt_reg == 2'h1) begin
      if (cold_sync_reg[1] || !option_sync_reg[1]) begin
        ctrl_reg <= `DETECTOR_CTRL_COLD_RESET;
      end else begin
        ctrl_reg <= `DETECTOR_CTRL_WARM_RESET;
      end
    end else if (wr_ctrl && write_protect_open) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Detection circuit control.
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_settle
      detect_settle_timer #(
        .CYCLES(SETTLE_CYCLES)
      ) u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl_reg[`DETECT0_BIT + gi]),
        .ready(settled[gi])
      );
    end
  endgenerate

  // Drives enables, monitoring state and the gated level-0 reset enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_power_en <= 3'h0;
      detect_active <= 3'h0;
      low_internal_power_en <= 1'b0;
      level0_reset_active <= 1'b0;
    end else begin
      detect_power_en <= ctrl_reg[`DETECT2_BIT:`DETECT0_BIT];
      detect_active <= settled;
      low_internal_power_en <= ctrl_reg[`LOW_POWER_BIT];
      level0_reset_active <= level0_reset_en && ctrl_reg.detect0_en;
    end
  end

  // Reads 1 while circuit 2 is off or settling, else the comparator level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level2_flag_reg <= 1'(`SUPPLY_MONITOR_STATUS_RESET >> `LEVEL2_FLAG_BIT);
    end else begin
      // The enable bit itself forces the flag so it does not lag the timer.
      level2_flag_reg <= !ctrl_reg.detect2_en || !settled[2] || cmp_sync_reg[1];
    end
  end

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  property p_flag_disabled;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_reg.detect2_en |=> level2_flag_reg;
  endproperty
  a_flag_disabled: assert property (p_flag_disabled) else $error("Flag low while off.");

  property p_flag_below;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg.detect2_en && settled[2] && !cmp_sync_reg[1]) |=> !level2_flag_reg;
  endproperty
  a_flag_below: assert property (p_flag_below) else $error("Flag high below threshold.");

  property p_status_hold;
    @(posedge pclk) disable iff (!presetn)
    !wr_status |=> $stable(status_reg);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("Status changed unwritten.");

  property p_reset_value;
    @(posedge pclk) disable iff (!presetn)
    (init_cnt_reg == 2'h1) |=>
      (ctrl_reg == (($past(cold_sync_reg[1]) || !$past(option_sync_reg[1])) ?
                    8'h20 : 8'h00));
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("Bad control reset value.");

  property p_ctrl_hold;
    @(posedge pclk) disable iff (!presetn)
    (init_cnt_reg == 2'h0 && !wr_ctrl) |=> $stable(ctrl_reg);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("Control changed unwritten.");

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
    (init_cnt_reg == 2'h0 && wr_ctrl && !write_protect_open) |=> $stable(ctrl_reg);
  endproperty
  a_protect: assert property (p_protect) else $error("Protected write took effect.");

  property p_enable_out;
    @(posedge pclk) disable iff (!presetn)
    ##1 detect_power_en == $past(ctrl_reg[7:5]);
  endproperty
  a_enable_out: assert property (p_enable_out) else $error("Enable outputs wrong.");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (init_cnt_reg == 2'h0 && wr_ctrl && write_protect_open) |=>
      (ctrl_reg.reserved == $past(pwdata[4:1]));
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits not stored.");

  property p_level0_gate;
    @(posedge pclk) disable iff (!presetn)
    level0_reset_active |-> $past(ctrl_reg.detect0_en);
  endproperty
  a_level0_gate: assert property (p_level0_gate) else $error("Level-0 reset ungated.");

  c_protected_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && write_protect_open);
  c_refused_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && !write_protect_open);
  c_detect2_live: cover property (@(posedge pclk) disable iff (!presetn)
    settled[2] && !level2_flag_reg);

endmodule

`default_nettype wire

//--- test_voltage_detect_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "voltage_detect_cfg.svh"

module test_voltage_detect_ctrl_regs;
  // ----------------------------------------------------------------------------
  // Parameters, signals and the table of ordinary bus cases.
  // ----------------------------------------------------------------------------
  localparam int settle = 8;
  localparam logic [11:0] stat_addr = {`SUPPLY_MONITOR_STATUS_IDX, 2'b00};
  localparam logic [11:0] ctrl_addr = {`DETECTOR_ENABLE_CONTROL_IDX, 2'b00};
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic wp;
    logic [31:0] exp;
    logic err;
  } row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cold_reset_cause, level0_startup_option, level2_cmp_above;
  logic write_protect_open, level0_reset_en, low_internal_power_en, level0_reset_active;
  logic [2:0] detect_power_en, detect_active;
  logic er;
  int errors, checks_done, cycles, n;
  row_s rows [10] = '{
    '{1'b0, ctrl_addr, 32'h0, 1'b0, 32'h20, 1'b0},  // Cold reset value.
    '{1'b1, ctrl_addr, 32'he1, 1'b0, 32'h0, 1'b0},  // Write while protected.
    '{1'b0, ctrl_addr, 32'h0, 1'b0, 32'h20, 1'b0},  // Value unchanged.
    '{1'b1, ctrl_addr, 32'hff, 1'b1, 32'h0, 1'b0},  // Write while open.
    '{1'b0, ctrl_addr, 32'h0, 1'b0, 32'hff, 1'b0},  // Reserved bits stored.
    '{1'b1, ctrl_addr, 32'h0, 1'b1, 32'h0, 1'b0},   // All circuits off.
    '{1'b1, stat_addr, 32'hf7, 1'b0, 32'h0, 1'b0},  // Flag bit written as 0.
    '{1'b0, stat_addr, 32'h0, 1'b0, 32'hff, 1'b0},  // Flag reads 1, circuit off.
    '{1'b0, 12'h000, 32'h0, 1'b0, 32'h0, 1'b1},     // Unmapped read.
    '{1'b1, 12'hffc, 32'h5a, 1'b1, 32'h0, 1'b1}     // Unmapped write.
  };

  voltage_detect_ctrl_regs #(.SETTLE_CYCLES(settle)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cold_reset_cause(cold_reset_cause), .level0_startup_option(level0_startup_option),
    .level2_cmp_above(level2_cmp_above), .write_protect_open(write_protect_open),
    .level0_reset_en(level0_reset_en), .detect_power_en(detect_power_en),
    .detect_active(detect_active), .low_internal_power_en(low_internal_power_en),
    .level0_reset_active(level0_reset_active)
  );

  // ----------------------------------------------------------------------------
  // Clock, timeout and helper tasks.
  // ----------------------------------------------------------------------------
  // Free running clock of 8 ns.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Cuts a hung run short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [2:0] got, input logic [2:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w >= 50) chk_word(32'h1, 32'h0, "no pready");
  endtask

  // Hardware reset with the given start-up straps.
  task automatic do_reset(input logic cold, input logic opt);
    cold_reset_cause <= cold;
    level0_startup_option <= opt;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cold_reset_cause = 1'b1;
    level0_startup_option = 1'b1;
    level2_cmp_above = 1'b1;
    write_protect_open = 1'b0;
    level0_reset_en = 1'b0;
    @(posedge pclk);
    do_reset(1'b1, 1'b1);
    // Table of ordinary cases.
    foreach (rows[i]) begin
      write_protect_open <= rows[i].wp;
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      chk_vec({2'b00, er}, {2'b00, rows[i].err}, "pslverr");
      if (!rows[i].wr) chk_word(rd, rows[i].exp, "read data");
    end
    $display("TEST table done");
    // Enabling all circuits: power at once, monitoring after the settle time.
    write_protect_open <= 1'b1;
    apb(1'b1, ctrl_addr, 32'he0);
    repeat (2) @(posedge pclk);
    chk_vec(detect_power_en, 3'b111, "power enables");
    chk_vec(detect_active, 3'b000, "active too early");
    n = 1;
    while (detect_active !== 3'b111 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk_vec({2'b00, n >= settle && n <= settle + 4}, 3'b001, "settle time");
    // Level-2 flag follows the comparator once circuit 2 monitors.
    level2_cmp_above <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, stat_addr, 32'h0);
    chk_word(rd, 32'hf7, "flag below");
    level2_cmp_above <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, stat_addr, 32'h0);
    chk_word(rd, 32'hff, "flag above");
    level0_reset_en <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_vec({2'b00, level0_reset_active}, 3'b001, "level0 reset on");
    // Only circuit 1 and low power: level-0 reset gated, flag forced to 1.
    level2_cmp_above <= 1'b0;
    apb(1'b1, ctrl_addr, 32'h41);
    repeat (4) @(posedge pclk);
    chk_vec({2'b00, level0_reset_active}, 3'b000, "level0 reset gated");
    chk_vec(detect_power_en, 3'b010, "power enables");
    chk_vec(detect_active, 3'b010, "active set");
    chk_vec({2'b00, low_internal_power_en}, 3'b001, "low power");
    apb(1'b0, stat_addr, 32'h0);
    chk_word(rd, 32'hff, "flag circuit off");
    $display("TEST settle and flag done");
    // Reset values for each strap combination except cold reset with option bit 0.
    for (int k = 0; k < 3; k++) begin
      do_reset(k == 2, k != 1);
      apb(1'b0, ctrl_addr, 32'h0);
      chk_word(rd, (k == 0) ? 32'h00 : 32'h20, "control reset");
      apb(1'b0, stat_addr, 32'h0);
      chk_word(rd, 32'h08, "status reset");
    end
    $display("TEST reset values done");
    give_verdict();
  end
endmodule

`default_nettype wire
